// *** baeu_pkg.sv ***
// package: op codes, widths, flag positions and reset values of the execution unit
`default_nettype none
package baeu_pkg;
   // -------------------------------------------------
   // widths
   // -------------------------------------------------
   localparam int unsigned DATA_W = 8;
   localparam int unsigned ADDR_W = 7;
   localparam int unsigned BIT_W  = 3;
   localparam int unsigned OP_W   = 4;
   // -------------------------------------------------
   // operation codes on the OP port
   // -------------------------------------------------
   localparam logic [3:0] OP_NONE      = 4'h0;
   localparam logic [3:0] OP_ADD_LIT   = 4'h1;
   localparam logic [3:0] OP_ADD_FILE  = 4'h2;
   localparam logic [3:0] OP_AND_LIT   = 4'h3;
   localparam logic [3:0] OP_AND_FILE  = 4'h4;
   localparam logic [3:0] OP_BIT_CLR   = 4'h5;
   localparam logic [3:0] OP_BIT_SET   = 4'h6;
   localparam logic [3:0] OP_SKIP_LOW  = 4'h7;
   localparam logic [3:0] OP_SKIP_HIGH = 4'h8;
   // -------------------------------------------------
   // flag positions and reset values
   // -------------------------------------------------
   localparam int unsigned FLAG_CARRY_POS = 0;
   localparam int unsigned FLAG_HALF_POS  = 1;
   localparam int unsigned FLAG_NULL_POS  = 2;
   localparam int unsigned HALF_BIT       = 4;
   localparam int unsigned CARRY_BIT      = 8;
   localparam logic [7:0] ACC_RST   = 8'h00;
   localparam logic [2:0] FLAGS_RST = 3'h0;
   localparam logic [6:0] ADDR_RST  = 7'h00;
   // destination select: 0 accumulator, 1 file register
   localparam logic DEST_ACC  = 1'b0;
   localparam logic DEST_FILE = 1'b1;
   typedef enum logic [1:0] {ST_RUN, ST_SQUASH} baeu_state_t;
endpackage
`default_nettype wire

// *** baeu_adder.sv ***
// adder with carry out of bit 3 and bit 7
`default_nettype none
module baeu_adder
   import baeu_pkg::*;
#(
   parameter int unsigned W = DATA_W
) (
   input  wire logic [W-1:0] a,
   input  wire logic [W-1:0] b,
   output logic      [W-1:0] sum,
   output logic              carry,
   output logic              half
);
   logic [W:0] full;
   logic [4:0] low;
   always_comb begin
      full  = {1'b0, a} + {1'b0, b};
      low   = {1'b0, a[3:0]} + {1'b0, b[3:0]};
      sum   = full[W-1:0];
      carry = full[W];
      half  = low[HALF_BIT];
   end
endmodule
`default_nettype wire

// *** baeu_bitmask.sv ***
// one-hot mask for a selected bit
`default_nettype none
module baeu_bitmask
   import baeu_pkg::*;
#(
   parameter int unsigned W = DATA_W
) (
   input  wire logic [BIT_W-1:0] sel,
   output logic      [W-1:0]     mask
);
   // -------------------------------------------------
   // decode per bit
   // -------------------------------------------------
   for (genvar i = 0; i < W; i++) begin : g_bit
      assign mask[i] = (sel == BIT_W'(i));
   end
endmodule
`default_nettype wire

// *** baeu_exec.sv ***
// execution unit for add, and, bit set/clear and bit test-and-skip
`default_nettype none
//
// Operation
// - add literal to accumulator, result to accumulator, update carry, half carry, null
// - add accumulator and file; destination 0 accumulator, 1 file; all three flags
// - and literal with accumulator into accumulator; only null flag changes
// - and accumulator with file into chosen destination; only null flag changes
// - clear selected bit of file register; no flag changes
// - set selected bit of file register; other bits and flags unchanged
// - skip if bit low: zero bit squashes next instruction, two cycles
// - skip if bit high: one bit squashes next instruction, two cycles
module baeu_exec
   import baeu_pkg::*;
(
   input  wire logic              CLK,
   input  wire logic              RST_N,
   input  wire logic              OP_VALID,
   input  wire logic [OP_W-1:0]   OP,
   input  wire logic [DATA_W-1:0] LITERAL,
   input  wire logic [ADDR_W-1:0] FILE_ADDR,
   input  wire logic              DEST,
   input  wire logic [BIT_W-1:0]  BIT_SEL,
   input  wire logic [DATA_W-1:0] FILE_RDATA,
   output logic      [ADDR_W-1:0] FILE_WADDR,
   output logic      [DATA_W-1:0] FILE_WDATA,
   output logic                   FILE_WE,
   output logic      [DATA_W-1:0] ACC,
   output logic                   CARRY,
   output logic                   HALF_CARRY_FLAG,
   output logic                   RESULT_NULL_FLAG,
   output logic                   SQUASH,
   output logic                   BUSY
);
   // -------------------------------------------------
   // operand preparation
   // -------------------------------------------------
   logic [DATA_W-1:0] acc_reg;
   logic [DATA_W-1:0] acc_next;
   logic [2:0]        flags_reg;
   logic [2:0]        flags_next;
   logic [ADDR_W-1:0] waddr_reg;
   logic [ADDR_W-1:0] waddr_next;
   logic [DATA_W-1:0] wdata_reg;
   logic [DATA_W-1:0] wdata_next;
   logic              we_reg;
   logic              we_next;
   logic              squash_reg;
   logic              squash_next;
   baeu_state_t       state_reg;
   baeu_state_t       state_next;
   logic              busy_reg;
   logic              busy_next;

   logic [DATA_W-1:0] add_b;
   logic [DATA_W-1:0] sum;
   logic              sum_carry;
   logic              sum_half;
   logic [DATA_W-1:0] mask;
   logic [DATA_W-1:0] and_b;
   logic [DATA_W-1:0] and_res;
   logic              tested_bit;
   logic              accept;

   assign accept     = OP_VALID && (state_reg == ST_RUN);
   assign add_b      = (OP == OP_ADD_LIT) ? LITERAL : FILE_RDATA;
   assign and_b      = (OP == OP_AND_LIT) ? LITERAL : FILE_RDATA;
   assign and_res    = acc_reg & and_b;
   assign tested_bit = |(FILE_RDATA & mask);

   baeu_adder #(
      .W (DATA_W)
   ) u_adder (
      .a     (acc_reg),
      .b     (add_b),
      .sum   (sum),
      .carry (sum_carry),
      .half  (sum_half)
   );

   baeu_bitmask #(
      .W (DATA_W)
   ) u_mask (
      .sel  (BIT_SEL),
      .mask (mask)
   );

   // -------------------------------------------------
   // next-state logic
   // -------------------------------------------------
   always_comb begin
      acc_next    = acc_reg;
      flags_next  = flags_reg;
      waddr_next  = waddr_reg;
      wdata_next  = wdata_reg;
      we_next     = 1'b0;
      squash_next = 1'b0;
      state_next  = ST_RUN;
      case (state_reg)
         ST_SQUASH: begin
            // no-operation cycle in place of the discarded instruction
            state_next = ST_RUN;
         end
         ST_RUN: begin
            if (accept) begin
               case (OP)
                  OP_ADD_LIT: begin
                     acc_next                  = sum;
                     flags_next[FLAG_CARRY_POS] = sum_carry;
                     flags_next[FLAG_HALF_POS]  = sum_half;
                     flags_next[FLAG_NULL_POS]  = (sum == '0);
                  end
                  OP_ADD_FILE: begin
                     flags_next[FLAG_CARRY_POS] = sum_carry;
                     flags_next[FLAG_HALF_POS]  = sum_half;
                     flags_next[FLAG_NULL_POS]  = (sum == '0);
                     if (DEST == DEST_FILE) begin
                        waddr_next = FILE_ADDR;
                        wdata_next = sum;
                        we_next    = 1'b1;
                     end else begin
                        acc_next = sum;
                     end
                  end
                  OP_AND_LIT: begin
                     acc_next                 = and_res;
                     flags_next[FLAG_NULL_POS] = (and_res == '0);
                  end
                  OP_AND_FILE: begin
                     flags_next[FLAG_NULL_POS] = (and_res == '0);
                     if (DEST == DEST_FILE) begin
                        waddr_next = FILE_ADDR;
                        wdata_next = and_res;
                        we_next    = 1'b1;
                     end else begin
                        acc_next = and_res;
                     end
                  end
                  OP_BIT_CLR: begin
                     waddr_next = FILE_ADDR;
                     wdata_next = FILE_RDATA & ~mask;
                     we_next    = 1'b1;
                  end
                  OP_BIT_SET: begin
                     waddr_next = FILE_ADDR;
                     wdata_next = FILE_RDATA | mask;
                     we_next    = 1'b1;
                  end
                  OP_SKIP_LOW: begin
                     if (!tested_bit) begin
                        squash_next = 1'b1;
                        state_next  = ST_SQUASH;
                     end
                  end
                  OP_SKIP_HIGH: begin
                     if (tested_bit) begin
                        squash_next = 1'b1;
                        state_next  = ST_SQUASH;
                     end
                  end
                  default: begin
                     acc_next = acc_reg;
                  end
               endcase
            end
         end
         default: begin
            state_next = ST_RUN;
         end
      endcase
      busy_next = (state_next == ST_SQUASH);
   end

   // -------------------------------------------------
   // registers
   // -------------------------------------------------
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         acc_reg    <= ACC_RST;
         flags_reg  <= FLAGS_RST;
         waddr_reg  <= ADDR_RST;
         wdata_reg  <= ACC_RST;
         we_reg     <= 1'b0;
         squash_reg <= 1'b0;
         state_reg  <= ST_RUN;
         busy_reg   <= 1'b0;
      end else begin
         acc_reg    <= acc_next;
         flags_reg  <= flags_next;
         waddr_reg  <= waddr_next;
         wdata_reg  <= wdata_next;
         we_reg     <= we_next;
         squash_reg <= squash_next;
         state_reg  <= state_next;
         busy_reg   <= busy_next;
      end
   end

   // -------------------------------------------------
   // outputs
   // -------------------------------------------------
   assign ACC              = acc_reg;
   assign CARRY            = flags_reg[FLAG_CARRY_POS];
   assign HALF_CARRY_FLAG  = flags_reg[FLAG_HALF_POS];
   assign RESULT_NULL_FLAG = flags_reg[FLAG_NULL_POS];
   assign FILE_WADDR       = waddr_reg;
   assign FILE_WDATA       = wdata_reg;
   assign FILE_WE          = we_reg;
   assign SQUASH           = squash_reg;
   assign BUSY             = busy_reg;
endmodule
`default_nettype wire

// *** baeu_exec_props.sv ***
// checker: port assertions of the execution unit
`default_nettype none
module baeu_exec_props
   import baeu_pkg::*;
(
   input wire logic       CLK,
   input wire logic       RST_N,
   input wire logic       OP_VALID,
   input wire logic [3:0] OP,
   input wire logic [7:0] LITERAL,
   input wire logic [6:0] FILE_ADDR,
   input wire logic       DEST,
   input wire logic [2:0] BIT_SEL,
   input wire logic [7:0] FILE_RDATA,
   input wire logic [6:0] FILE_WADDR,
   input wire logic [7:0] FILE_WDATA,
   input wire logic       FILE_WE,
   input wire logic [7:0] ACC,
   input wire logic       CARRY,
   input wire logic       HALF_CARRY_FLAG,
   input wire logic       RESULT_NULL_FLAG,
   input wire logic       SQUASH,
   input wire logic       BUSY
);
   timeunit 1ns;
   timeprecision 1ps;
   logic       tk, cy, hc, bv, ad, lt;
   logic [7:0] ob, s8, a8, r8, m8, bw;
   assign tk = OP_VALID && !BUSY;
   assign ad = OP == OP_ADD_LIT || OP == OP_ADD_FILE;
   assign lt = OP == OP_ADD_LIT || OP == OP_AND_LIT;
   assign ob = lt ? LITERAL : FILE_RDATA;
   assign {cy, s8} = {1'h0, ACC} + {1'h0, ob};
   assign hc = {1'h0, ACC[3:0]} + {1'h0, ob[3:0]} > 5'h0f;
   assign a8 = ACC & ob;
   assign r8 = ad ? s8 : a8;
   assign m8 = 8'h01 << BIT_SEL;
   assign bw = (OP == OP_BIT_SET) ? (FILE_RDATA | m8) : (FILE_RDATA & ~m8);
   assign bv = FILE_RDATA[BIT_SEL];
   default clocking @(posedge CLK); endclocking
   default disable iff (!RST_N);
   add_lit_a: assert property (tk && OP == OP_ADD_LIT |=> ACC == $past(s8))
      else $error("add literal result wrong");
   add_flags_a: assert property (tk && ad |=> CARRY == $past(cy) && HALF_CARRY_FLAG == $past(hc))
      else $error("add carry flags wrong");
   add_file_a: assert property (tk && OP == OP_ADD_FILE && DEST |=> FILE_WE
      && FILE_WADDR == $past(FILE_ADDR) && FILE_WDATA == $past(s8) && $stable(ACC))
      else $error("add to file wrong");
   and_acc_a: assert property (tk && (OP == OP_AND_LIT || OP == OP_AND_FILE && !DEST)
      |=> ACC == $past(a8) && $stable(CARRY) && $stable(HALF_CARRY_FLAG))
      else $error("and result or carries wrong");
   null_flag_a: assert property (tk && OP inside {[OP_ADD_LIT:OP_AND_FILE]}
      |=> RESULT_NULL_FLAG == ($past(r8) == 8'h00))
      else $error("null flag wrong");
   bit_write_a: assert property ((tk && (OP == OP_BIT_CLR || OP == OP_BIT_SET))
      |=> FILE_WE && FILE_WADDR == $past(FILE_ADDR) && FILE_WDATA == $past(bw))
      else $error("bit write wrong");
   bit_flags_a: assert property (tk && OP inside {[OP_BIT_CLR:OP_SKIP_HIGH]}
      |=> $stable({CARRY, HALF_CARRY_FLAG, RESULT_NULL_FLAG}))
      else $error("flags moved on bit op");
   skip_taken_a: assert property (tk && (OP == OP_SKIP_LOW && !bv || OP == OP_SKIP_HIGH && bv)
      |=> SQUASH && BUSY ##1 !SQUASH && !BUSY)
      else $error("skip not two cycles");
   skip_none_a: assert property (tk && (OP == OP_SKIP_LOW && bv || OP == OP_SKIP_HIGH && !bv)
      |=> !SQUASH && !BUSY)
      else $error("skip where none due");
   busy_ignore_a: assert property (OP_VALID && BUSY |=> !FILE_WE && !SQUASH && !BUSY
      && $stable(ACC) && $stable({CARRY, HALF_CARRY_FLAG, RESULT_NULL_FLAG}))
      else $error("op taken in no-op cycle");
   cover property (tk && OP == OP_SKIP_HIGH && bv);
   cover property (tk && OP == OP_ADD_FILE && DEST);
   cover property (OP_VALID && BUSY);
endmodule
bind baeu_exec baeu_exec_props baeu_exec_props_i (.CLK(CLK), .RST_N(RST_N),
   .OP_VALID(OP_VALID), .OP(OP), .LITERAL(LITERAL), .FILE_ADDR(FILE_ADDR), .DEST(DEST),
   .BIT_SEL(BIT_SEL), .FILE_RDATA(FILE_RDATA), .FILE_WADDR(FILE_WADDR),
   .FILE_WDATA(FILE_WDATA), .FILE_WE(FILE_WE), .ACC(ACC), .CARRY(CARRY),
   .HALF_CARRY_FLAG(HALF_CARRY_FLAG), .RESULT_NULL_FLAG(RESULT_NULL_FLAG),
   .SQUASH(SQUASH), .BUSY(BUSY));
`default_nettype wire

// *** baeu_rf_model.sv ***
// partner: file register array behind the execution unit
`default_nettype none
module baeu_rf_model
   import baeu_pkg::*;
(
   input  wire logic       clk,
   input  wire logic [6:0] raddr,
   input  wire logic [6:0] waddr,
   input  wire logic [7:0] wdata,
   input  wire logic       we,
   output logic      [7:0] rdata
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] mem [128];
   initial begin
      for (int i = 0; i < 128; i++) begin
         mem[i] = 8'(i);
      end
   end
   // forward a write that has not landed yet
   assign rdata = (we && waddr == raddr) ? wdata : mem[raddr];
   always @(posedge clk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
   end
endmodule
`default_nettype wire

// *** tb.sv ***
// testbench: operation table, add during busy and reset cases
`default_nettype none
module tb
   import baeu_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {
      logic [3:0] op; logic [7:0] lit; logic [6:0] adr; logic dst; logic [2:0] bs;
      logic [7:0] acc; logic [2:0] fl; logic sq;
   } baeu_row_t;
   logic       CLK = 1'h0, RST_N = 1'h0, OP_VALID = 1'h0, DEST = 1'h0;
   logic [3:0] OP = OP_NONE;
   logic [7:0] LITERAL = 8'h00, FILE_RDATA, FILE_WDATA, ACC;
   logic [6:0] FILE_ADDR = 7'h00, FILE_WADDR;
   logic [2:0] BIT_SEL = 3'h0;
   logic       FILE_WE, CARRY, HALF_CARRY_FLAG, RESULT_NULL_FLAG, SQUASH, BUSY;
   int         n_fail = 0, cmp_count = 0, cyc = 0;
   baeu_row_t rows [14] = '{
      '{OP_ADD_LIT, 8'hff, 7'h00, 1'h0, 3'h0, 8'hff, 3'h0, 1'h0},
      '{OP_ADD_LIT, 8'h01, 7'h00, 1'h0, 3'h0, 8'h00, 3'h7, 1'h0},
      '{OP_AND_LIT, 8'h0f, 7'h00, 1'h0, 3'h0, 8'h00, 3'h7, 1'h0},
      '{OP_ADD_LIT, 8'h3c, 7'h00, 1'h0, 3'h0, 8'h3c, 3'h0, 1'h0},
      '{OP_ADD_FILE, 8'h00, 7'h48, 1'h0, 3'h0, 8'h84, 3'h2, 1'h0},
      '{OP_ADD_FILE, 8'h00, 7'h7f, 1'h1, 3'h0, 8'h84, 3'h6, 1'h0},
      '{OP_AND_FILE, 8'h00, 7'h7f, 1'h0, 3'h0, 8'h00, 3'h7, 1'h0},
      '{OP_AND_FILE, 8'h00, 7'h05, 1'h1, 3'h0, 8'h00, 3'h7, 1'h0},
      '{OP_BIT_SET, 8'h00, 7'h05, 1'h0, 3'h7, 8'h00, 3'h7, 1'h0},
      '{OP_BIT_CLR, 8'h00, 7'h7f, 1'h0, 3'h0, 8'h00, 3'h7, 1'h0},
      '{OP_SKIP_LOW, 8'h00, 7'h7f, 1'h0, 3'h0, 8'h00, 3'h7, 1'h1},
      '{OP_SKIP_HIGH, 8'h00, 7'h05, 1'h0, 3'h7, 8'h00, 3'h7, 1'h1},
      '{OP_SKIP_LOW, 8'h00, 7'h05, 1'h0, 3'h7, 8'h00, 3'h7, 1'h0},
      '{OP_SKIP_HIGH, 8'h00, 7'h7f, 1'h0, 3'h0, 8'h00, 3'h7, 1'h0}};
   baeu_exec baeu_exec_i (.CLK(CLK), .RST_N(RST_N), .OP_VALID(OP_VALID), .OP(OP),
      .LITERAL(LITERAL), .FILE_ADDR(FILE_ADDR), .DEST(DEST), .BIT_SEL(BIT_SEL),
      .FILE_RDATA(FILE_RDATA), .FILE_WADDR(FILE_WADDR), .FILE_WDATA(FILE_WDATA),
      .FILE_WE(FILE_WE), .ACC(ACC), .CARRY(CARRY), .HALF_CARRY_FLAG(HALF_CARRY_FLAG),
      .RESULT_NULL_FLAG(RESULT_NULL_FLAG), .SQUASH(SQUASH), .BUSY(BUSY));
   baeu_rf_model baeu_rf_model_i (.clk(CLK), .raddr(FILE_ADDR), .waddr(FILE_WADDR),
      .wdata(FILE_WDATA), .we(FILE_WE), .rdata(FILE_RDATA));
   always #4 CLK = ~CLK;
   task automatic check(input string nm, input logic [7:0] exp, input logic [7:0] got);
      cmp_count++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic put(input int k);
      OP_VALID  <= 1'h1;
      OP        <= rows[k].op;
      LITERAL   <= rows[k].lit;
      FILE_ADDR <= rows[k].adr;
      DEST      <= rows[k].dst;
      BIT_SEL   <= rows[k].bs;
   endtask
   task automatic end_sim;
      $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   always @(posedge CLK) begin
      cyc <= cyc + 1;
      if (cyc == 300) begin
         n_fail++;
         end_sim();
      end
   end
   initial begin
      logic we_exp;
      repeat (4) @(posedge CLK);
      RST_N <= 1'h1;
      put(0);
      for (int i = 0; i < 14; i++) begin
         @(posedge CLK);
         if (rows[i].sq) begin
            OP      <= OP_ADD_LIT;
            LITERAL <= 8'h11;
         end else if (i < 13) begin
            put(i + 1);
         end else begin
            OP_VALID <= 1'h0;
         end
         we_exp = rows[i].op inside {OP_BIT_CLR, OP_BIT_SET}
            || rows[i].dst && rows[i].op inside {OP_ADD_FILE, OP_AND_FILE};
         @(negedge CLK);
         check("acc", rows[i].acc, ACC);
         check("flags", 8'(rows[i].fl), 8'({CARRY, HALF_CARRY_FLAG, RESULT_NULL_FLAG}));
         check("squash", 8'(rows[i].sq), 8'(SQUASH));
         check("busy", 8'(rows[i].sq), 8'(BUSY));
         check("write strobe", 8'(we_exp), 8'(FILE_WE));
         if (we_exp) begin
            check("write address", 8'(rows[i].adr), 8'(FILE_WADDR));
         end
         if (rows[i].sq) begin
            @(posedge CLK);
            if (i < 13) begin
               put(i + 1);
            end else begin
               OP_VALID <= 1'h0;
            end
            @(negedge CLK);
            check("op in no-op cycle", 8'h00, ACC);
            check("end of no-op cycle", 8'h00, 8'({SQUASH, BUSY, FILE_WE}));
         end
      end
      check("cleared bit", 8'h02, baeu_rf_model_i.mem[127]);
      check("set bit", 8'h80, baeu_rf_model_i.mem[5]);
      @(posedge CLK);
      OP_VALID <= 1'h1;
      OP       <= OP_ADD_LIT;
      LITERAL  <= 8'h5a;
      @(posedge CLK);
      OP_VALID <= 1'h0;
      @(negedge CLK);
      check("acc before reset", 8'h5a, ACC);
      @(posedge CLK);
      RST_N <= 1'h0;
      #3;
      check("acc in reset", 8'h00, ACC);
      check("flags in reset", 8'h00, 8'({CARRY, HALF_CARRY_FLAG, RESULT_NULL_FLAG}));
      check("strobes in reset", 8'h00, 8'({FILE_WE, SQUASH, BUSY}));
      repeat (2) @(posedge CLK);
      RST_N    <= 1'h1;
      OP_VALID <= 1'h1;
      LITERAL  <= 8'h01;
      @(posedge CLK);
      OP_VALID <= 1'h0;
      @(negedge CLK);
      check("acc after reset", 8'h01, ACC);
      check("flags after reset", 8'h00, 8'({CARRY, HALF_CARRY_FLAG, RESULT_NULL_FLAG}));
      end_sim();
   end
endmodule
`default_nettype wire
